// ===== rtl/irdc_config.sv
// Resource decode configuration register bank with EEPROM load
`timescale 1ns/1ps
`include "irdc_defs.svh"
module irdc_config #(
  parameter int ADDR_W = 8
) (
  input  wire logic              clk_sys,
  input  wire logic              nrst,
  input  wire logic [ADDR_W-1:0] avsAddress,
  input  wire logic              avsRead,
  input  wire logic              avsWrite,
  input  wire logic [31:0]       avsWriteData,
  input  wire logic [3:0]        avsByteEnable,
  output logic      [31:0]       avsReadData,
  output logic                   avsWaitRequest,
  input  wire logic              eeWordValid,
  input  wire logic [7:0]        eeWordIndex,
  input  wire logic [15:0]       eeWordData,
  input  wire logic              eepromBusyIn,
  input  wire logic [2:0]        archMode,
  input  wire logic [16:13]      sysAddr,
  input  wire logic [3:0]        ioAddrLow,
  input  wire logic              ioBaseMatch,
  input  wire logic              memReadN,
  input  wire logic              memWriteN,
  input  wire logic              latchStrobe,
  input  wire logic              aenIn,
  input  wire logic              ioReadN,
  input  wire logic              ioWriteN,
  input  wire logic              twistedPairActive,
  input  wire logic              sleepEntered,
  input  wire logic              stdKeySeen,
  input  wire logic              altKeySeen,
  input  wire logic              irq12Normal,
  input  wire logic              irq15Normal,
  output logic                   eepromLoadBusy,
  output logic                   keyAccepted,
  output logic                   relocatableMode,
  output logic                   xcvrSelectOut,
  output logic                   bootRomSelectN,
  output logic                   memCs16N,
  output logic                   ioCs16N,
  output logic                   ioSelect,
  output logic                   irq12Pin,
  output logic                   irq15Pin,
  output logic [7:0]             addrRamData,
  output logic                   addrRamReadValid
);
  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Size code to mask of compared address bits 15..13
  function automatic logic [2:0] size_mask(input logic [3:0] sz);
    case (sz)
      4'b1111: size_mask = 3'b111;
      4'b1110: size_mask = 3'b110;
      4'b1100: size_mask = 3'b100;
      4'b1000: size_mask = 3'b000;
      default: size_mask = 3'b111;
    endcase
  endfunction
  function automatic logic size_valid(input logic [3:0] sz);
    size_valid = sz[3] && (sz == 4'b1111 || sz == 4'b1110 || sz == 4'b1100 || sz == 4'b1000);
  endfunction
  function automatic logic [7:0] field_hi(input logic [7:0] fix, input logic b);
    field_hi = {fix[7:1], b};
  endfunction

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  logic [3:0]  bootRomLocation;
  logic        bootRomWideFlag;
  logic [3:0]  bootRomSize;
  logic [4:0]  sharedRamLocation;
  logic        sharedRamWideFlag;
  logic [3:0]  sharedRamSize;
  logic [7:0]  vendorOptionByte;
  logic [7:0]  checksum;
  logic        loadGood;
  logic [7:0]  addrRam [0:15];
  logic [2:0]  busySync;
  logic        eeAbsent;
  irdc_pkg::irdc_load_type loadState;
  logic [7:0]  regByte;
  logic        regHit;
  logic        wrByte;
  logic [7:0]  wd;
  logic        isMaster;
  logic        isShared;
  logic        bootHit;
  logic        bootWin;
  logic        sramHit;
  logic        ioHit;

  assign wd       = avsWriteData[7:0];
  assign wrByte   = avsWrite && avsByteEnable[0] && !avsWaitRequest;
  assign isMaster = archMode == 3'(irdc_pkg::IRDC_BUS_MASTER);
  assign isShared = archMode == 3'(irdc_pkg::IRDC_SHARED_MEM);

  // Pin input synchroniser for the busy pin
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      // Unequal stages force a full settle before any decision
      busySync <= 3'h2;
    end else begin
      busySync <= {busySync[1:0], eepromBusyIn};
    end
  end

  // Floating busy pin held low by pull: no EEPROM
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      eeAbsent <= 1'b0;
    end else if (loadState == irdc_pkg::IRDC_LD_IDLE && busySync[2] == busySync[1]) begin
      eeAbsent <= !busySync[2];
    end
  end

  // ----------------------------------------------------------------
  // EEPROM load and checksum
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      loadState <= irdc_pkg::IRDC_LD_IDLE;
      checksum  <= 8'h00;
      loadGood  <= 1'b0;
    end else begin
      case (loadState)
        irdc_pkg::IRDC_LD_IDLE: begin
          if (busySync[2] == busySync[1]) begin
            loadState <= busySync[2] ? irdc_pkg::IRDC_LD_READ : irdc_pkg::IRDC_LD_DONE;
          end
        end
        irdc_pkg::IRDC_LD_READ: begin
          if (eeWordValid && eeWordIndex <= `IRDC_CSUM_LAST) begin
            checksum <= checksum + eeWordData[15:8] + eeWordData[7:0];
          end
          if (eeWordValid && eeWordIndex == `IRDC_EE_WORDS - 8'h01) begin
            loadState <= irdc_pkg::IRDC_LD_DONE;
            loadGood  <= checksum == `IRDC_CSUM_GOOD;
          end
        end
        irdc_pkg::IRDC_LD_DONE: loadState <= irdc_pkg::IRDC_LD_DONE;
        default: loadState <= irdc_pkg::IRDC_LD_IDLE;
      endcase
    end
  end

  // busy high during load, low only if good
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      eepromLoadBusy <= 1'b1;
    end else begin
      eepromLoadBusy <= !(loadState == irdc_pkg::IRDC_LD_DONE && loadGood);
    end
  end

  // relocatable mode on bad or missing EEPROM
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      relocatableMode <= 1'b0;
    end else begin
      relocatableMode <= loadState == irdc_pkg::IRDC_LD_DONE && !loadGood;
    end
  end

  // ----------------------------------------------------------------
  // Register writes from load and bus
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      bootRomLocation   <= 4'h0;
      bootRomWideFlag   <= 1'b0;
      bootRomSize       <= 4'h0;
      sharedRamLocation <= 5'h00;
      sharedRamWideFlag <= 1'b0;
      sharedRamSize     <= 4'h0;
      vendorOptionByte  <= `IRDC_RESET_BYTE;
    end else if (loadState == irdc_pkg::IRDC_LD_READ && eeWordValid) begin
      case (eeWordIndex)
        8'h18: begin
          bootRomLocation <= eeWordData[3:0];
          bootRomSize     <= eeWordData[7:4];
          bootRomWideFlag <= eeWordData[8];
        end
        8'h19: begin
          sharedRamLocation <= eeWordData[4:0];
          sharedRamSize     <= eeWordData[11:8];
          sharedRamWideFlag <= eeWordData[12];
        end
        `IRDC_VENDOR_WORD: vendorOptionByte <= eeWordData[7:0];
        default: begin
        end
      endcase
    end else if (wrByte) begin
      case (avsAddress)
        `IRDC_OFF_BROM_LOC_HI:  bootRomLocation[3] <= wd[0];
        `IRDC_OFF_BROM_LOC_LO:  bootRomLocation[2:0] <= wd[7:5];
        `IRDC_OFF_BROM_WIDTH:   bootRomWideFlag <= wd[`IRDC_WIDTH_BIT];
        `IRDC_OFF_BROM_SIZE_HI: bootRomSize[3] <= wd[0];
        `IRDC_OFF_BROM_SIZE_LO: bootRomSize[2:0] <= wd[7:5];
        // upper shared bits taken as written
        `IRDC_OFF_SRAM_LOC_HI:  sharedRamLocation[4:3] <= wd[1:0];
        `IRDC_OFF_SRAM_LOC_LO:  sharedRamLocation[2:0] <= wd[7:5];
        `IRDC_OFF_SRAM_WIDTH:   sharedRamWideFlag <= wd[`IRDC_WIDTH_BIT];
        `IRDC_OFF_SRAM_SIZE_HI: sharedRamSize[3] <= wd[0];
        `IRDC_OFF_SRAM_SIZE_LO: sharedRamSize[2:0] <= wd[7:5];
        `IRDC_OFF_VENDOR:       vendorOptionByte <= {1'b0, wd[6:0]};
        default: begin
        end
      endcase
    end
  end

  // station address copied from serial EEPROM
  always_ff @(posedge clk_sys) begin
    if (loadState == irdc_pkg::IRDC_LD_READ && eeWordValid && eeWordIndex < 8'h08) begin
      addrRam[{eeWordIndex[2:0], 1'b0}] <= eeWordData[7:0];
      addrRam[{eeWordIndex[2:0], 1'b1}] <= eeWordData[15:8];
    end
  end

  // ----------------------------------------------------------------
  // Avalon slave read path
  // ----------------------------------------------------------------
  always_comb begin
    regHit  = 1'b1;
    regByte = 8'h00;
    case (avsAddress)
      `IRDC_OFF_BROM_LOC_HI:  regByte = field_hi(`IRDC_LOC_HI_FIXED, bootRomLocation[3]);
      `IRDC_OFF_BROM_LOC_LO:  regByte = {bootRomLocation[2:0], 5'h00};
      `IRDC_OFF_BROM_WIDTH:   regByte = {6'h00, bootRomWideFlag, 1'b0};
      `IRDC_OFF_BROM_SIZE_HI: regByte = field_hi(`IRDC_SIZE_HI_FIXED, bootRomSize[3]);
      `IRDC_OFF_BROM_SIZE_LO: regByte = {bootRomSize[2:0], 5'h00};
      `IRDC_OFF_SRAM_LOC_HI:  regByte = {6'h03, sharedRamLocation[4:3]};
      `IRDC_OFF_SRAM_LOC_LO:  regByte = {sharedRamLocation[2:0], 5'h00};
      `IRDC_OFF_SRAM_WIDTH:   regByte = {6'h00, sharedRamWideFlag, 1'b0};
      `IRDC_OFF_SRAM_SIZE_HI: regByte = field_hi(`IRDC_SIZE_HI_FIXED, sharedRamSize[3]);
      `IRDC_OFF_SRAM_SIZE_LO: regByte = {sharedRamSize[2:0], 5'h00};
      `IRDC_OFF_VENDOR:       regByte = vendorOptionByte;
      `IRDC_OFF_STATUS:       regByte = {4'h0, eeAbsent, relocatableMode, loadGood,
                                         eepromLoadBusy};
      `IRDC_OFF_MODE:         regByte = {6'h00, loadState};
      default: begin
        regHit  = 1'b0;
        regByte = 8'h00;
      end
    endcase
  end

  // One wait cycle per access, unmapped reads return zero
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      avsWaitRequest <= 1'b1;
      avsReadData    <= 32'h0000_0000;
    end else begin
      avsWaitRequest <= !((avsRead || avsWrite) && avsWaitRequest);
      if (avsRead && avsWaitRequest) begin
        avsReadData <= {24'h00_0000, regHit ? regByte : 8'h00};
      end
    end
  end

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  logic [2:0] bootMask;
  logic [2:0] sramMask;
  logic       bootSelLatch;
  assign bootMask = size_mask(bootRomSize);
  assign sramMask = size_mask(sharedRamSize);
  // low latch strobe as upper-address select
  assign bootSelLatch = vendorOptionByte[`IRDC_V_BSEL] ? !latchStrobe : 1'b1;

  always_comb begin
    // boot window on SA 16..13, or on SA 15..13 with latch select, size aligned
    bootWin = size_valid(bootRomSize) && bootSelLatch
              && (vendorOptionByte[`IRDC_V_BSEL] || sysAddr[16] == bootRomLocation[3])
              && (((sysAddr[15:13] ^ bootRomLocation[2:0]) & bootMask) == 3'b000);
    bootHit = bootWin && !memReadN;
    // shared decode only in shared mode
    sramHit = isShared && size_valid(sharedRamSize) && (!memReadN || !memWriteN)
              && (((sysAddr[15:13] ^ sharedRamLocation[2:0]) & sramMask) == 3'b000);
    ioHit = vendorOptionByte[`IRDC_V_EXTIO] ? !aenIn : (!aenIn && ioBaseMatch);
  end

  // ----------------------------------------------------------------
  // Registered pin outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      bootRomSelectN <= 1'b1;
      memCs16N       <= 1'b1;
      ioCs16N        <= 1'b1;
      ioSelect       <= 1'b0;
      irq12Pin       <= 1'b0;
      irq15Pin       <= 1'b0;
      xcvrSelectOut  <= 1'b0;
    end else begin
      // flash remap of IRQ12 in master and shared modes, of boot select in shared mode only
      if (vendorOptionByte[`IRDC_V_FLASH] && isMaster) begin
        bootRomSelectN <= !bootHit;
        irq12Pin       <= !(bootWin && !memWriteN);
      end else if (vendorOptionByte[`IRDC_V_FLASH] && isShared) begin
        bootRomSelectN <= !(bootWin && (!memReadN || !memWriteN));
        irq12Pin       <= !sramHit;
      end else begin
        bootRomSelectN <= !bootHit;
        irq12Pin       <= irq12Normal;
      end
      memCs16N <= !((bootHit && bootRomWideFlag && !isMaster) || (sramHit && sharedRamWideFlag));
      // I/O 16 select from mode bit
      ioCs16N  <= !(ioHit && vendorOptionByte[`IRDC_V_IOMODE]);
      ioSelect <= ioHit;
      irq15Pin <= vendorOptionByte[`IRDC_V_APROM] ? !(ioHit && !ioReadN) : irq15Normal;
      xcvrSelectOut <= (twistedPairActive || sleepEntered) ^ vendorOptionByte[`IRDC_V_XPOL];
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      addrRamData      <= 8'h00;
      addrRamReadValid <= 1'b0;
    end else begin
      addrRamReadValid <= ioHit && !ioReadN && !vendorOptionByte[`IRDC_V_APROM];
      addrRamData      <= addrRam[ioAddrLow];
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      keyAccepted <= 1'b0;
    end else if (vendorOptionByte[`IRDC_V_LEGACY] || !loadGood) begin
      keyAccepted <= altKeySeen;
    end else begin
      keyAccepted <= stdKeySeen;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_loadDone;
    loadState == irdc_pkg::IRDC_LD_DONE;
  endsequence
  property p_busyGood;
    @(posedge clk_sys) disable iff (!nrst) s_loadDone and loadGood |=> !eepromLoadBusy;
  endproperty
  a_busyGood: assert property (p_busyGood) else $error("busy not low after good load");
  property p_busyBad;
    @(posedge clk_sys) disable iff (!nrst) !loadGood |=> eepromLoadBusy;
  endproperty
  a_busyBad: assert property (p_busyBad) else $error("busy fell without good load");
  property p_reloc;
    @(posedge clk_sys) disable iff (!nrst) s_loadDone and !loadGood |=> relocatableMode;
  endproperty
  a_reloc: assert property (p_reloc) else $error("relocatable mode missing");
  property p_legacy;
    @(posedge clk_sys) disable iff (!nrst)
      vendorOptionByte[`IRDC_V_LEGACY] && stdKeySeen && !altKeySeen |=> !keyAccepted;
  endproperty
  a_legacy: assert property (p_legacy) else $error("standard key taken in legacy");
  property p_stdKey;
    @(posedge clk_sys) disable iff (!nrst)
      !vendorOptionByte[`IRDC_V_LEGACY] && loadGood && stdKeySeen |=> keyAccepted;
  endproperty
  a_stdKey: assert property (p_stdKey) else $error("standard key refused");
  property p_xcvr;
    @(posedge clk_sys) disable iff (!nrst)
      1'b1 |=> xcvrSelectOut == ($past(twistedPairActive || sleepEntered)
                                ^ $past(vendorOptionByte[`IRDC_V_XPOL]));
  endproperty
  a_xcvr: assert property (p_xcvr) else $error("transceiver select wrong");
  property p_io16;
    @(posedge clk_sys) disable iff (!nrst)
      !vendorOptionByte[`IRDC_V_IOMODE] |=> ioCs16N;
  endproperty
  a_io16: assert property (p_io16) else $error("I/O 16 in 8-bit mode");
  property p_master8;
    @(posedge clk_sys) disable iff (!nrst) isMaster && !isShared |=> memCs16N;
  endproperty
  a_master8: assert property (p_master8) else $error("16-bit answer in bus master");
  property p_noBoot;
    @(posedge clk_sys) disable iff (!nrst)
      !bootRomSize[3] && !vendorOptionByte[`IRDC_V_FLASH] |=> bootRomSelectN;
  endproperty
  a_noBoot: assert property (p_noBoot) else $error("boot select with no ROM");
endmodule

// ===== rtl/irdc_defs.svh
// Register offsets, field positions, reset values and EEPROM load constants
`ifndef IRDC_DEFS_SVH
`define IRDC_DEFS_SVH
`define IRDC_OFF_BROM_LOC_HI   8'h40
`define IRDC_OFF_BROM_LOC_LO   8'h41
`define IRDC_OFF_BROM_WIDTH    8'h42
`define IRDC_OFF_BROM_SIZE_HI  8'h43
`define IRDC_OFF_BROM_SIZE_LO  8'h44
`define IRDC_OFF_SRAM_LOC_HI   8'h48
`define IRDC_OFF_SRAM_LOC_LO   8'h49
`define IRDC_OFF_SRAM_WIDTH    8'h4a
`define IRDC_OFF_SRAM_SIZE_HI  8'h4b
`define IRDC_OFF_SRAM_SIZE_LO  8'h4c
`define IRDC_OFF_VENDOR        8'hf0
`define IRDC_OFF_STATUS        8'hf8
`define IRDC_OFF_MODE          8'hf9
`define IRDC_LOC_HI_FIXED      8'h0c
`define IRDC_SIZE_HI_FIXED     8'hfe
`define IRDC_WIDTH_BIT         1
`define IRDC_V_LEGACY          6
`define IRDC_V_XPOL            5
`define IRDC_V_FLASH           4
`define IRDC_V_BSEL            3
`define IRDC_V_APROM           2
`define IRDC_V_EXTIO           1
`define IRDC_V_IOMODE          0
`define IRDC_CSUM_LAST         8'h1b
`define IRDC_CSUM_GOOD         8'hff
`define IRDC_EE_WORDS          8'h40
`define IRDC_VENDOR_WORD       8'h1a
`define IRDC_RESET_BYTE        8'h00
`endif

// ===== rtl/irdc_pkg.sv
// Types of the resource decode configuration block
package irdc_pkg;
  typedef enum logic [1:0] {
    IRDC_BUS_MASTER = 2'b00,
    IRDC_SHARED_MEM = 2'b01,
    IRDC_PIO        = 2'b10
  } irdc_arch_type;
  typedef enum logic [1:0] {
    IRDC_LD_IDLE = 2'b00,
    IRDC_LD_READ = 2'b01,
    IRDC_LD_DONE = 2'b10
  } irdc_load_type;
endpackage

// ===== verification/irdc_ee_model.sv
// EEPROM word source and external scan chain model
`timescale 1ns/1ps
module irdc_ee_model (
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  input  wire logic        present,
  input  wire logic        corrupt,
  input  wire logic        busyOut,
  output logic             eeWordValid,
  output logic [7:0]       eeWordIndex,
  output logic [15:0]      eeWordData,
  output logic             busyPin,
  output logic             sent,
  output logic [15:0]      chainLatch
);
  logic [15:0] mem [0:63];
  logic [7:0]  step;
  logic [7:0]  sum;
  logic        busyLast;
  logic [3:0]  lead;
  // Upper shared location bits left zero
  always_comb begin
    sum = 8'h00;
    for (int i = 0; i < 64; i++) begin
      mem[i] = {2{i[7:0]}};
    end
    mem[24] = 16'h01f3;
    mem[25] = 16'h1f02;
    mem[26] = 16'h0001;
    for (int i = 0; i < 27; i++) begin
      sum = sum + mem[i][15:8] + mem[i][7:0];
    end
    mem[27] = {8'h00, 8'hff - sum - {7'h00, corrupt}};
  end
  // Unconnected pin reads low
  assign busyPin = present ? busyOut : 1'b0;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      step        <= 8'h00;
      lead        <= 4'h0;
      eeWordValid <= 1'b0;
      eeWordIndex <= 8'h00;
      eeWordData  <= 16'h0000;
      sent        <= 1'b0;
      busyLast    <= 1'b0;
      chainLatch  <= 16'h0000;
    end else begin
      // Hold off until the loader has left its settle state
      if (lead != 4'h8) begin
        lead <= lead + 4'h1;
      end else if (!sent) begin
        step <= step + 8'h01;
      end
      eeWordValid <= present && !sent && lead == 4'h8 && !step[0];
      eeWordIndex <= {1'b0, step[7:1]};
      eeWordData  <= mem[step[6:1]];
      sent        <= sent || (step == 8'h7f);
      busyLast    <= busyPin;
      if (busyLast && !busyPin) begin
        chainLatch <= mem[27];
      end
    end
  end
endmodule

// ===== verification/testbench.sv
// Self-checking testbench of the resource decode configuration block
`timescale 1ns/1ps
module testbench;
  logic        clk_sys = 1'b0, nrst = 1'b0, present = 1'b1, corrupt = 1'b0;
  logic [7:0]  avsAddress = 8'h00, addrRamData;
  logic        avsRead = 1'b0, avsWrite = 1'b0, avsWaitRequest, eeWordValid, sent;
  logic [31:0] avsWriteData = 32'h0000_0000, avsReadData;
  logic [3:0]  avsByteEnable = 4'h0, ioAddrLow = 4'h0;
  logic [7:0]  eeWordIndex;
  logic [15:0] eeWordData;
  logic [2:0]  archMode = 3'h0;
  logic [16:13] sysAddr = 4'h0;
  logic        eepromBusyIn, ioBaseMatch = 1'b0, memReadN = 1'b1, memWriteN = 1'b1;
  logic        latchStrobe = 1'b0, aenIn = 1'b0, ioReadN = 1'b1, ioWriteN = 1'b1;
  logic        twistedPairActive = 1'b0, sleepEntered = 1'b0, stdKeySeen = 1'b0;
  logic        altKeySeen = 1'b0, irq12Normal = 1'b0, irq15Normal = 1'b0;
  logic        eepromLoadBusy, keyAccepted, relocatableMode, xcvrSelectOut;
  logic        bootRomSelectN, memCs16N, ioCs16N, ioSelect, irq12Pin, irq15Pin;
  logic        addrRamReadValid;
  logic [15:0] chainLatch;
  int          errCount = 0, nTests = 0, cycles = 0;

  irdc_config dut (.clk_sys, .nrst, .avsAddress, .avsRead, .avsWrite, .avsWriteData,
    .avsByteEnable, .avsReadData, .avsWaitRequest, .eeWordValid, .eeWordIndex,
    .eeWordData, .eepromBusyIn, .archMode, .sysAddr, .ioAddrLow, .ioBaseMatch,
    .memReadN, .memWriteN, .latchStrobe, .aenIn, .ioReadN, .ioWriteN,
    .twistedPairActive, .sleepEntered, .stdKeySeen, .altKeySeen, .irq12Normal,
    .irq15Normal, .eepromLoadBusy, .keyAccepted, .relocatableMode, .xcvrSelectOut,
    .bootRomSelectN, .memCs16N, .ioCs16N, .ioSelect, .irq12Pin, .irq15Pin,
    .addrRamData, .addrRamReadValid);
  irdc_ee_model partner (.clk_sys, .nrst, .present, .corrupt, .busyOut(eepromLoadBusy),
    .eeWordValid, .eeWordIndex, .eeWordData, .busyPin(eepromBusyIn), .sent,
    .chainLatch);

  always #25 clk_sys = ~clk_sys;

  // ----------------------------------------
  // Common tasks
  // ----------------------------------------
  task automatic endOfTest();
    $display("comparisons %0d mismatches %0d", nTests, errCount);
    if (errCount == 0 && nTests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nTests++;
    if (got !== exp) begin
      errCount++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk({31'h0000_0000, got}, {31'h0000_0000, exp});
  endtask
  task automatic w2();
    repeat (2) @(posedge clk_sys);
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d,
                     output logic [31:0] q);
    int n = 0;
    @(posedge clk_sys);
    avsAddress    <= a;
    avsWriteData  <= {24'h00_0000, d};
    avsByteEnable <= 4'h1;
    avsWrite      <= wr;
    avsRead       <= !wr;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avsWaitRequest !== 1'b0);
    q = avsReadData;
    chk(n, 2);
    avsWrite <= 1'b0;
    avsRead  <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, q);
    chk(q, {24'h00_0000, e});
  endtask
  task automatic do_reset(input logic p, input logic c);
    int n = 0;
    @(posedge clk_sys);
    present <= p;
    corrupt <= c;
    nrst    <= 1'b0;
    repeat (4) @(posedge clk_sys);
    chk1(eepromLoadBusy, 1'b1);
    nrst <= 1'b1;
    while (!sent && n < 400) begin
      @(posedge clk_sys);
      n++;
    end
    repeat (4) @(posedge clk_sys);
  endtask
  task automatic key(input logic s, input logic a, input logic e);
    stdKeySeen <= s;
    altKeySeen <= a;
    w2();
    chk1(keyAccepted, e);
    stdKeySeen <= 1'b0;
    altKeySeen <= 1'b0;
    w2();
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_load();
    logic [7:0] offs [12] = '{8'h40, 8'h41, 8'h42, 8'h43, 8'h44, 8'h48, 8'h49,
                              8'h4a, 8'h4b, 8'h4c, 8'hf0, 8'h10};
    logic [7:0] exps [12] = '{8'h0c, 8'h60, 8'h02, 8'hff, 8'he0, 8'h0c, 8'h40,
                              8'h02, 8'hff, 8'he0, 8'h01, 8'h00};
    do_reset(1'b1, 1'b0);
    chk1(eepromLoadBusy, 1'b0);
    chk1(relocatableMode, 1'b0);
    chk({16'h0000, chainLatch}, 32'h0000_00c1);
    for (int i = 0; i < 12; i++) begin
      rd(offs[i], exps[i]);
    end
    $display("test load done");
  endtask
  task automatic t_keys();
    key(1'b1, 1'b0, 1'b1);
    wr(8'hf0, 8'h41);
    key(1'b1, 1'b0, 1'b0);
    key(1'b0, 1'b1, 1'b1);
    wr(8'hf0, 8'h01);
    $display("test keys done");
  endtask
  task automatic t_xcvr();
    logic pol;
    for (int i = 0; i < 6; i++) begin
      pol = (i >= 3);
      wr(8'hf0, {2'b00, pol, 5'h01});
      twistedPairActive <= (i % 3 == 1);
      sleepEntered      <= (i % 3 == 2);
      w2();
      chk1(xcvrSelectOut, (i % 3 != 0) ^ pol);
    end
    $display("test xcvr done");
  endtask
  task automatic t_boot();
    archMode    <= 3'h1;
    sysAddr     <= 4'h3;
    latchStrobe <= 1'b1;
    memReadN    <= 1'b0;
    w2();
    chk1(bootRomSelectN, 1'b0);
    chk1(memCs16N, 1'b0);
    sysAddr <= 4'h2;
    w2();
    chk1(bootRomSelectN, 1'b1);
    chk1(memCs16N, 1'b0);
    archMode <= 3'h2;
    w2();
    chk1(memCs16N, 1'b1);
    archMode <= 3'h0;
    w2();
    chk1(memCs16N, 1'b1);
    sysAddr <= 4'h3;
    w2();
    chk1(memCs16N, 1'b1);
    wr(8'hf0, 8'h09);
    latchStrobe <= 1'b0;
    w2();
    chk1(bootRomSelectN, 1'b0);
    latchStrobe <= 1'b1;
    w2();
    chk1(bootRomSelectN, 1'b1);
    wr(8'hf0, 8'h11);
    w2();
    chk1(bootRomSelectN, 1'b0);
    chk1(irq12Pin, 1'b1);
    memReadN  <= 1'b1;
    memWriteN <= 1'b0;
    w2();
    chk1(bootRomSelectN, 1'b1);
    chk1(irq12Pin, 1'b0);
    archMode <= 3'h1;
    w2();
    chk1(bootRomSelectN, 1'b0);
    chk1(irq12Pin, 1'b1);
    sysAddr <= 4'h2;
    w2();
    chk1(bootRomSelectN, 1'b1);
    chk1(irq12Pin, 1'b0);
    memWriteN <= 1'b1;
    memReadN  <= 1'b0;
    archMode  <= 3'h0;
    sysAddr   <= 4'h3;
    wr(8'hf0, 8'h01);
    wr(8'h43, 8'hfe);
    w2();
    chk1(bootRomSelectN, 1'b1);
    rd(8'h43, 8'hfe);
    memReadN <= 1'b1;
    $display("test boot done");
  endtask
  task automatic t_io();
    ioAddrLow   <= 4'h3;
    ioBaseMatch <= 1'b1;
    ioReadN     <= 1'b0;
    w2();
    chk1(ioCs16N, 1'b0);
    chk1(addrRamReadValid, 1'b1);
    chk({24'h00_0000, addrRamData}, 32'h0000_0001);
    chk1(irq15Pin, 1'b0);
    wr(8'hf0, 8'h04);
    w2();
    chk1(addrRamReadValid, 1'b0);
    ioReadN <= 1'b1;
    w2();
    chk1(irq15Pin, 1'b1);
    ioReadN <= 1'b0;
    wr(8'hf0, 8'h00);
    w2();
    chk1(ioCs16N, 1'b1);
    chk1(ioSelect, 1'b1);
    wr(8'hf0, 8'h02);
    ioBaseMatch <= 1'b0;
    w2();
    chk1(ioSelect, 1'b1);
    aenIn <= 1'b1;
    w2();
    chk1(ioSelect, 1'b0);
    ioReadN <= 1'b1;
    aenIn   <= 1'b0;
    $display("test io done");
  endtask
  task automatic t_fail();
    do_reset(1'b1, 1'b1);
    chk1(eepromLoadBusy, 1'b1);
    chk({16'h0000, chainLatch}, 32'h0000_0000);
    chk1(relocatableMode, 1'b1);
    key(1'b1, 1'b0, 1'b0);
    key(1'b0, 1'b1, 1'b1);
    do_reset(1'b0, 1'b0);
    chk1(relocatableMode, 1'b1);
    rd(8'hf8, 8'h0d);
    key(1'b0, 1'b1, 1'b1);
    $display("test fail done");
  endtask

  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      errCount++;
      endOfTest();
    end
  end

  initial begin
    t_load();
    t_keys();
    t_xcvr();
    t_boot();
    t_io();
    t_fail();
    endOfTest();
  end
endmodule
